/* rtl/cfg_link_if.sv */
// Link between the loader and the configuration port it feeds
`timescale 1ns/100ps
interface cfg_link_if;
  logic config_clock;   // One-cycle tick per configuration clock edge
  logic serial_data;
  logic serial_data_oe;
  logic init_out;       // Open drain, driven by the configuration port
  logic init_oe;
  logic done;
  logic program_request_pin_out;       // Open drain, driven by the loader
  logic program_request_pin_oe;
  logic init_level;
  logic data_level;
  logic program_request_pin_level;

  // Pull-ups resolve the undriven lines high
  assign init_level = init_oe ? init_out : 1'b1;
  assign data_level = serial_data_oe ? serial_data : 1'b1;
  assign program_request_pin_level = program_request_pin_oe ? program_request_pin_out : 1'b1;

  modport loader (
    input  config_clock,
    input  init_level,
    input  done,
    output serial_data,
    output serial_data_oe,
    output program_request_pin_out,
    output program_request_pin_oe
  );

  modport port (
    output config_clock,
    output init_out,
    output init_oe,
    output done,
    input  data_level,
    input  program_request_pin_level
  );
endinterface : cfg_link_if

/* rtl/config_loader.sv */
// Loader end: parallel memory reader, two-entry buffer and serialiser
`timescale 1ns/100ps
`include "loader_cfg.svh"

// ==========================================================
// Two-entry style buffer, flip-flop storage addressed by index
module byte_fifo #(
  parameter int WIDTH = `BYTE_W,
  parameter int DEPTH = `FIFO_DEPTH_DEF
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             do_push;
  logic             do_pop;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  // Pointers wrap at DEPTH so any depth works
  always_ff @(posedge core_clk)
  begin
    if (rst || (ce && flush))
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (ce)
    begin
      if (do_push)
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (do_push && !do_pop)
        count <= count + 1'b1;
      else if (do_pop && !do_push)
        count <= count - 1'b1;
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge core_clk)
  begin
    if (ce && do_push)
      mem[wr_ptr] <= in_data;
  end
endmodule : byte_fifo

// ==========================================================
// Loader top
module config_loader #(
  parameter int PROM_ADDR_W = `PROM_ADDR_W_DEF,
  parameter int SEL_W       = `SEL_W_DEF,
  parameter int START_DELAY = 0,
  parameter bit RETRY_EN    = 1'b0,
  parameter int PROM_WAIT   = `PROM_WAIT_DEF,
  parameter int FIFO_DEPTH  = `FIFO_DEPTH_DEF
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  input  wire logic                           ce,
  cfg_link_if.loader                          link,
  output logic [PROM_ADDR_W+SEL_W-1:0]        prom_addr,
  output logic [(1<<SEL_W)-1:0]               prom_enable_n,
  input  wire logic [`BYTE_W-1:0]             prom_data,
  output logic                                busy,
  output logic                                config_done
);
  import loader_pkg::*;

  localparam int ADDR_W  = PROM_ADDR_W + SEL_W;
  localparam int N_PROM  = 1 << SEL_W;
  localparam int PROGRAM_REQUEST_PIN_CY = `PROGRAM_REQUEST_PIN_PULSE_CYC;

  loader_state_t        state;
  logic [15:0]          delay_cnt;
  logic [7:0]           program_request_pin_cnt;
  logic [7:0]           wait_cnt;
  logic                 tick;
  logic                 init_hi;
  logic                 fill_valid;
  logic                 fill_ready;
  logic                 drain_valid;
  logic                 drain_ready;
  logic [`BYTE_W-1:0]   drain_data;
  logic [`BYTE_W-1:0]   shift_reg;
  logic [3:0]           bits_left;
  logic [N_PROM-1:0]    next_enable_n;
  logic                 loading;

  // The configuration clock tick paces the serial bits; memory wait and program pulse count core cycles
  assign tick    = link.config_clock;
  assign init_hi = link.init_level;
  assign loading = (state == ST_LOAD) && !link.done;

  // ========================================================
  // Sequence control
  always_ff @(posedge core_clk)
  begin
    if (rst)
      state <= ST_IDLE;
    else if (ce)
    begin
      case (state)
        ST_IDLE:
          if (!init_hi)
            state <= ST_CLEAR;
        ST_CLEAR:
          if (init_hi)
            state <= (START_DELAY == 0) ? ST_LOAD : ST_DELAY;
        ST_DELAY:
          if (!init_hi)
            state <= ST_CLEAR;
          else if (tick && delay_cnt == 16'(START_DELAY - 1))
            state <= ST_LOAD;
        ST_LOAD:
          if (link.done)
            state <= ST_DONE;
          else if (!init_hi)
            state <= RETRY_EN ? ST_PROGRAM_REQUEST_PIN : ST_IDLE;
        ST_PROGRAM_REQUEST_PIN:
          if (program_request_pin_cnt == 8'(PROGRAM_REQUEST_PIN_CY - 1))
            state <= ST_CLEAR;
        ST_DONE:
          if (!init_hi)
            state <= ST_CLEAR;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Start delay counts configuration clocks after init rises
  always_ff @(posedge core_clk)
  begin
    if (rst)
      delay_cnt <= '0;
    else if (ce)
    begin
      if (state != ST_DELAY)
        delay_cnt <= '0;
      else if (tick)
        delay_cnt <= delay_cnt + 1'b1;
    end
  end

  // Program pulse lasts at least 300 ns
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      program_request_pin_cnt     <= '0;
      link.program_request_pin_oe <= 1'b0;
    end
    else if (ce)
    begin
      program_request_pin_cnt     <= (state == ST_PROGRAM_REQUEST_PIN) ? program_request_pin_cnt + 1'b1 : '0;
      link.program_request_pin_oe <= (state == ST_PROGRAM_REQUEST_PIN);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      link.program_request_pin_out <= 1'b1;
    else if (ce)
      link.program_request_pin_out <= 1'b0;   // Open drain: only the enable matters
  end

  // ========================================================
  // Memory fetch; the buffer's ready holds the address back
  assign fill_valid = loading && (wait_cnt == 8'(PROM_WAIT));

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prom_addr <= '0;
      wait_cnt  <= '0;
    end
    else if (ce)
    begin
      if (!loading)
      begin
        if (state != ST_LOAD)
          prom_addr <= '0;
        wait_cnt <= '0;
      end
      else if (fill_valid && fill_ready)
      begin
        prom_addr <= prom_addr + 1'b1;
        wait_cnt  <= '0;
      end
      else if (wait_cnt != 8'(PROM_WAIT))
        wait_cnt <= wait_cnt + 1'b1;
    end
  end

  // One-of-N active-low enable from the top address bits
  always_comb
  begin
    next_enable_n = '1;
    for (int i = 0; i < N_PROM; i++)
      if (loading && (prom_addr >> PROM_ADDR_W) == ADDR_W'(i))
        next_enable_n[i] = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      prom_enable_n <= '1;
    else if (ce)
      prom_enable_n <= next_enable_n;
  end

  byte_fifo #(
    .WIDTH (`BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .ce        (ce),
    .flush     (state != ST_LOAD),
    .in_valid  (fill_valid),
    .in_ready  (fill_ready),
    .in_data   (prom_data),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_data)
  );

  // ========================================================
  // Serialiser: a new byte loads when the last bit is clocked
  assign drain_ready = loading && (bits_left == 4'h0 || (tick && bits_left == 4'h1));

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      shift_reg        <= '0;
      bits_left        <= '0;
      link.serial_data <= 1'b1;
    end
    else if (ce)
    begin
      if (!loading)
        bits_left <= '0;
      else if (drain_valid && drain_ready)
      begin
        link.serial_data <= drain_data[0];
        shift_reg        <= drain_data >> 1;
        bits_left        <= 4'h8;
      end
      else if (tick && bits_left != 4'h0)
      begin
        link.serial_data <= shift_reg[0];
        shift_reg        <= shift_reg >> 1;
        bits_left        <= bits_left - 1'b1;
      end
    end
  end

  // Data line released outside loading, so done isolates us
  always_ff @(posedge core_clk)
  begin
    if (rst)
      link.serial_data_oe <= 1'b0;
    else if (ce)
      link.serial_data_oe <= loading && init_hi;
  end

  // ========================================================
  // Status
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      busy        <= 1'b0;
      config_done <= 1'b0;
    end
    else if (ce)
    begin
      busy        <= (state == ST_DELAY) || (state == ST_LOAD);
      config_done <= (state == ST_DONE);
    end
  end
endmodule : config_loader

/* rtl/config_port.sv */
// Far end: serial configuration port that clocks, checks length and reports
`timescale 1ns/100ps
`include "loader_cfg.svh"

module config_port #(
  parameter int LENGTH_W   = `LENGTH_W_DEF,
  parameter int INIT_CLEAR = `INIT_CLEAR_DEF,
  parameter int CONFIG_CLOCK_DIV   = `CONFIG_CLOCK_DIV_DEF
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                ce,
  cfg_link_if.port                 link,
  input  wire logic                osc_mode,
  input  wire logic                osc_tick,
  input  wire logic                hold,
  input  wire logic                force_error,
  input  wire logic [LENGTH_W-1:0] length_count,
  input  wire logic [7:0]          ready_delay,
  output logic [`BYTE_W-1:0]       rx_byte,
  output logic                     rx_valid
);
  import loader_pkg::*;

  port_state_t         state;
  logic [15:0]         clear_cnt;
  logic [7:0]          ready_cnt;
  logic [7:0]          div_cnt;
  logic [LENGTH_W-1:0] clk_count;
  logic [`BYTE_W-1:0]  rx_shift;
  logic [3:0]          rx_cnt;
  logic                accepting;
  logic                program_request_pin_low;

  assign accepting = (state == FP_CONFIG) && (ready_cnt >= ready_delay);
  assign program_request_pin_low  = !link.program_request_pin_level;

  // ========================================================
  // Port sequence: clear, configure, done or error
  always_ff @(posedge core_clk)
  begin
    if (rst)
      state <= FP_CLEAR;
    else if (ce)
    begin
      case (state)
        FP_CLEAR:
          if (!program_request_pin_low && clear_cnt == 16'(INIT_CLEAR - 1))
            state <= FP_CONFIG;
        FP_CONFIG:
          if (program_request_pin_low)
            state <= FP_CLEAR;
          else if (force_error)
            state <= FP_ERROR;
          else if (link.config_clock && clk_count == length_count - 1'b1)
            state <= FP_DONE;
        FP_DONE, FP_ERROR:
          if (program_request_pin_low)
            state <= FP_CLEAR;
        default:
          state <= FP_CLEAR;
      endcase
    end
  end

  // Clear time and older-family wait, both in core cycles
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      clear_cnt <= '0;
      ready_cnt <= '0;
    end
    else if (ce)
    begin
      clear_cnt <= (state == FP_CLEAR && !program_request_pin_low) ? clear_cnt + 1'b1 : '0;
      if (state != FP_CONFIG)
        ready_cnt <= '0;
      else if (ready_cnt != 8'hff)
        ready_cnt <= ready_cnt + 1'b1;
    end
  end

  // Init and done pins
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      link.init_out <= 1'b0;
      link.init_oe  <= 1'b1;
      link.done     <= 1'b0;
    end
    else if (ce)
    begin
      link.init_out <= 1'b0;
      link.init_oe  <= (state == FP_CLEAR) || (state == FP_ERROR) || program_request_pin_low;
      link.done     <= (state == FP_DONE);
    end
  end

  // ========================================================
  // Clock ticks: own divider withheld until ready, or oscillator
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      div_cnt           <= '0;
      link.config_clock <= 1'b0;
    end
    else if (ce)
    begin
      div_cnt <= (div_cnt == 8'(CONFIG_CLOCK_DIV - 1)) ? '0 : div_cnt + 1'b1;
      if (osc_mode)
        link.config_clock <= osc_tick && (state == FP_CONFIG);
      else
        link.config_clock <= accepting && !hold && div_cnt == '0;
    end
  end

  // Length counts every clock from init rise, dummy bits included
  always_ff @(posedge core_clk)
  begin
    if (rst)
      clk_count <= '0;
    else if (ce)
    begin
      if (state != FP_CONFIG)
        clk_count <= '0;
      else if (link.config_clock)
        clk_count <= clk_count + 1'b1;
    end
  end

  // Capture: first clocked bit lands in byte bit 0
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_shift <= '0;
      rx_cnt   <= '0;
      rx_byte  <= '0;
      rx_valid <= 1'b0;
    end
    else if (ce)
    begin
      rx_valid <= 1'b0;
      if (!accepting)
        rx_cnt <= '0;
      else if (link.config_clock)
      begin
        rx_shift <= {link.data_level, rx_shift[`BYTE_W-1:1]};
        rx_cnt   <= (rx_cnt == 4'h7) ? 4'h0 : rx_cnt + 1'b1;
        if (rx_cnt == 4'h7)
        begin
          rx_byte  <= {link.data_level, rx_shift[`BYTE_W-1:1]};
          rx_valid <= 1'b1;
        end
      end
    end
  end
endmodule : config_port

/* rtl/loader_cfg.svh */
// Constants for the parallel-memory serial configuration loader and its far end
`ifndef LOADER_CFG_SVH
`define LOADER_CFG_SVH
// How it works
// - Loader paces bits from the configuration clock, memory wait and program pulse from core cycles
// - One oscillator clocks both ends alike
// - Far end withholds its own divider clocks until it is ready; oscillator ticks are not withheld
// - Memory address width parameter, default 19
// - Width 17/18/19/20 for 1M/2M/4M/8M bits
// - Init low while loading returns to reset state
// - Optional: pulse program low, then retry
// - Extra top address bits decode memory enables
// - Two memories: bit 19 picks enable 0/1
// - More memories: one-of-N active-low enable decode
// - Older families need extra wait after init
// - Optional start delay counted after init rises
// - Alternative: 40 dummy bits, longer length count
// - Far end counts clocks up to length
// - Newer families: shift at once after init
// - First clocked bit is byte bit 0
// - Chained far ends share lines, loader unchanged
// - Buffer reads up to FIFO_DEPTH bytes ahead of the serialiser
// - Done: disable memories, release serial data

// ==========================================================
// Clock and timing
`define CLK_MHZ          100
`define PROGRAM_REQUEST_PIN_PULSE_NS    300
`define PROGRAM_REQUEST_PIN_PULSE_CYC   ((`PROGRAM_REQUEST_PIN_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define OLD_FAMILY_DELAY 40

// ==========================================================
// Structure defaults
`define PROM_ADDR_W_DEF  19
`define SEL_W_DEF        0
`define BYTE_W           8
`define PROM_WAIT_DEF    2
`define FIFO_DEPTH_DEF   2
`define INIT_CLEAR_DEF   16
`define CONFIG_CLOCK_DIV_DEF     4
`define LENGTH_W_DEF     24
`endif

/* rtl/loader_pkg.sv */
// Types shared by both ends of the configuration link
package loader_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CLEAR = 3'h1,
    ST_DELAY = 3'h2,
    ST_LOAD  = 3'h3,
    ST_PROGRAM_REQUEST_PIN  = 3'h4,
    ST_DONE  = 3'h5
  } loader_state_t;

  typedef enum logic [1:0] {
    FP_CLEAR  = 2'h0,
    FP_CONFIG = 2'h1,
    FP_DONE   = 2'h2,
    FP_ERROR  = 2'h3
  } port_state_t;
endpackage : loader_pkg

/* testbench/config_link_asserts.sv */
// Concurrent checks on the loader link and the memory side of the loader
`timescale 1ns/100ps
`include "loader_cfg.svh"

// ==========================================================
// Link checker
module config_link_asserts #(
  parameter int ADDR_W = 20
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              config_clock,
  input wire logic              serial_data_oe,
  input wire logic              init_level,
  input wire logic              done,
  input wire logic              program_request_pin_out,
  input wire logic              program_request_pin_oe,
  input wire logic [ADDR_W-1:0] prom_addr,
  input wire logic [1:0]        prom_enable_n,
  input wire logic              config_done
);
  logic [7:0] program_request_pin_len;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Cycles the program line has been driven, so the pulse width can be judged
  always_ff @(posedge core_clk)
  begin
    if (rst || !program_request_pin_oe)
      program_request_pin_len <= 8'h00;
    else
      program_request_pin_len <= program_request_pin_len + 8'h01;
  end

  // ==========================================================
  // Memory side
  a_enable_decode: assert property (
    prom_enable_n != 2'b11 && $stable(prom_addr)
    |-> prom_enable_n == (prom_addr[ADDR_W-1] ? 2'b01 : 2'b10))
    else $error("memory enable does not follow top address bit");
  a_enable_onehot: assert property ($onehot0(~prom_enable_n))
    else $error("more than one memory enabled");
  a_addr_step: assert property (
    prom_addr != $past(prom_addr) |-> prom_addr == $past(prom_addr) + 1'b1 || prom_addr == '0)
    else $error("memory address skipped");

  // ==========================================================
  // Link side
  a_start_at_once: assert property ($rose(init_level) |-> ##[1:4] serial_data_oe)
    else $error("serial data not driven soon after init rose");
  a_oe_needs_init: assert property (serial_data_oe |-> $past(init_level))
    else $error("serial data driven while init low");
  a_error_release: assert property (
    $fell(init_level) && serial_data_oe |-> ##[1:2] !serial_data_oe)
    else $error("serial data still driven after init fell");
  a_program_request_pin_cause: assert property (
    $rose(program_request_pin_oe) |-> !program_request_pin_out && !init_level && $past(!init_level))
    else $error("program pulse without an init error");
  a_program_request_pin_width: assert property ($fell(program_request_pin_oe) |-> program_request_pin_len == `PROGRAM_REQUEST_PIN_PULSE_CYC)
    else $error("program pulse has the wrong width");
  a_done_isolate: assert property (
    $rose(done) |-> ##[1:3] (!serial_data_oe && prom_enable_n == 2'b11 && config_done))
    else $error("loader not isolated after done");
  a_done_idle: assert property (
    config_done && $past(config_done) && init_level
    |-> !serial_data_oe && prom_enable_n == 2'b11)
    else $error("loader woke after done");

  // Main scenarios reached
  c_done_seen: cover property ($rose(done));
  c_program_request_pin_pulse: cover property ($rose(program_request_pin_oe));
  c_second_memory: cover property (prom_enable_n == 2'b01 && config_clock);
endmodule : config_link_asserts

/* testbench/test_parallel_prom_serial_config_loader.sv */
// Self-checking bench joining the loader and the configuration port
`timescale 1ns/100ps

module test_parallel_prom_serial_config_loader;
  logic        core_clk;
  logic        rst;
  logic        ce;
  logic [3:0]  prom_addr;
  logic [1:0]  prom_enable_n;
  logic [7:0]  prom_data;
  logic        busy;
  logic        config_done;
  logic        osc_mode;
  logic        osc_tick;
  logic        hold;
  logic        force_error;
  logic [23:0] length_count;
  logic [7:0]  ready_delay;
  logic [7:0]  rx_byte;
  logic        rx_valid;
  logic [7:0]  mem [16];
  logic [7:0]  exp_q [$];
  logic [31:0] seed;
  logic [15:0] lead_bits;
  int          nbit;
  int          init_cnt;
  int          errors;
  int          checked;

  // ==========================================================
  // Two memories of eight bytes each, so the enable decode is exercised
  cfg_link_if link ();
  config_loader #(.PROM_ADDR_W(3), .SEL_W(1), .RETRY_EN(1'b1)) config_loader_i (
    .core_clk(core_clk), .rst(rst), .ce(ce), .link(link.loader), .prom_addr(prom_addr),
    .prom_enable_n(prom_enable_n), .prom_data(prom_data), .busy(busy),
    .config_done(config_done));
  config_port #(.INIT_CLEAR(4)) config_port_i (
    .core_clk(core_clk), .rst(rst), .ce(ce), .link(link.port), .osc_mode(osc_mode),
    .osc_tick(osc_tick), .hold(hold), .force_error(force_error),
    .length_count(length_count), .ready_delay(ready_delay), .rx_byte(rx_byte),
    .rx_valid(rx_valid));
  config_link_asserts #(.ADDR_W(4)) config_link_asserts_i (
    .core_clk(core_clk), .rst(rst), .config_clock(link.config_clock),
    .serial_data_oe(link.serial_data_oe), .init_level(link.init_level), .done(link.done),
    .program_request_pin_out(link.program_request_pin_out), .program_request_pin_oe(link.program_request_pin_oe), .prom_addr(prom_addr),
    .prom_enable_n(prom_enable_n), .config_done(config_done));

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic tally_and_finish();
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // Every load starts again from address zero, so the whole image is expected
  task automatic note_all();
    exp_q.delete();
    foreach (mem[i])
      exp_q.push_back(mem[i]);
  endtask : note_all

  // Bounded wait for the stream to drain to a level, optionally until done
  task automatic wait_for(input int left, input bit need_done, input int limit);
    int n;
    n = 0;
    while ((exp_q.size() > left || (need_done && config_done !== 1'b1)) && n < limit)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= limit)
    begin
      errors++;
      $display("MISMATCH at %0t: stream stalled", $time);
      tally_and_finish();
    end
  endtask : wait_for

  // ==========================================================
  // Memory model and random stimulus; a deselected memory floats, shown as
  // an inverted pattern so a wrong enable decode corrupts the data
  always @(negedge core_clk)
  begin
    seed = lfsr_next(seed);
    init_cnt = (link.init_level === 1'b1) ? init_cnt + 1 : 0;
    hold <= !osc_mode && seed[3:0] == 4'h0;
    osc_tick <= osc_mode && init_cnt > 10 && seed[0];
    prom_data <= (prom_enable_n === (prom_addr[3] ? 2'b01 : 2'b10)) ? mem[prom_addr]
                                                                    : ~prom_data;
  end

  // ==========================================================
  // Monitors: received bytes against the notes, and the first wire bits
  always @(posedge core_clk)
  begin
    // A frozen pulse is counted once, at the first enabled edge
    if (!rst && ce === 1'b1 && rx_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(1'b0, "byte arrived with none expected");
      else
        check(rx_byte === exp_q.pop_front(), "received byte differs from memory");
    end
  end

  always @(posedge core_clk)
  begin
    if (rst || link.init_level !== 1'b1)
      nbit = 0;
    else if (link.config_clock === 1'b1 && nbit < 16)
    begin
      lead_bits[nbit] = link.data_level;
      nbit++;
      if (nbit == 16)
        check(lead_bits === 16'h4fff, "fill and preamble bits out of order");
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    errors = 0;
    checked = 0;
    seed = 32'hc3e8;
    init_cnt = 0;
    nbit = 0;
    rst = 1'b1;
    ce = 1'b1;
    osc_mode = 1'b0;
    osc_tick = 1'b0;
    hold = 1'b0;
    force_error = 1'b0;
    length_count = 24'h000080;
    ready_delay = 8'h08;
    prom_data = 8'h00;
    foreach (mem[i])
    begin
      seed = lfsr_next(seed);
      mem[i] = seed[7:0];
    end
    mem[0] = 8'hff;
    mem[1] = 8'h4f;
    note_all();
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    // Port-clocked run with random clock stalls and a clock-enable pause
    wait_for(8, 1'b0, 4000);
    check(busy === 1'b1, "busy low while loading");
    ce = 1'b0;
    repeat (5) @(negedge core_clk);
    ce = 1'b1;
    wait_for(0, 1'b1, 4000);
    check(exp_q.size() == 0, "bytes missing at done");
    repeat (3) @(negedge core_clk);
    check(link.serial_data_oe === 1'b0 && prom_enable_n === 2'b11, "not isolated");
    repeat (40) @(negedge core_clk);
    check(config_done === 1'b1 && link.serial_data_oe === 1'b0, "left done idle");
    // Oscillator run: error after five bytes, then a retry from address zero
    rst = 1'b1;
    osc_mode = 1'b1;
    ready_delay = 8'h00;
    note_all();
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    wait_for(11, 1'b0, 4000);
    force_error = 1'b1;
    @(negedge core_clk);
    force_error = 1'b0;
    // A byte finishing on the error edge still belongs to the old image
    repeat (2) @(negedge core_clk);
    note_all();
    wait_for(0, 1'b1, 8000);
    check(exp_q.size() == 0 && config_done === 1'b1, "retry did not complete");
    tally_and_finish();
  end
endmodule : test_parallel_prom_serial_config_loader
